// file: rtl/usrbg_pkg.sv
package usrbg_pkg;
   // ****************************************
   // register addresses
   // ****************************************
   localparam logic [7:0] RSC_ADDR  = 8'h18;
   localparam logic [7:0] HOLD_ADDR = 8'h1a;
   localparam logic [7:0] IST_ADDR  = 8'h20;
   localparam logic [7:0] ICLR_ADDR = 8'h21;
   localparam logic [7:0] IEN_ADDR  = 8'h22;
   localparam logic [7:0] TSC_ADDR  = 8'h98;
   localparam logic [7:0] DIV_ADDR  = 8'h99;
   // ****************************************
   // field positions
   // ****************************************
   localparam int RSC_SERIAL_PORT_ENABLE   = 7;
   localparam int RSC_NINE   = 6;
   localparam int RSC_SINGLE_RECEIVE_ENABLE   = 5;
   localparam int RSC_CONTINUOUS_RECEIVE_ENABLE   = 4;
   localparam int TSC_MASTER = 7;
   localparam int TSC_SYNC   = 4;
   localparam int TSC_HIGH   = 2;
   localparam int IRQ_RX     = 0;
   localparam int IRQ_FRAMING_ERROR_FLAG   = 1;
   localparam int IRQ_OVERRUN_ERROR_FLAG   = 2;
   localparam int IRQ_W      = 3;
   // ****************************************
   // reset values and counts
   // ****************************************
   localparam logic [7:0]       DIV_RST    = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RST    = 3'h0;
   localparam int               BAUD_W     = 8;
   localparam logic [1:0]       PRE_LAST   = 2'h3;
   localparam logic [3:0]       PHASE_ZERO = 4'h0;
   localparam logic [3:0]       SAMP_FIRST = 4'h7;
   localparam logic [3:0]       SAMP_MID   = 4'h8;
   localparam logic [3:0]       SAMP_LAST  = 4'h9;
   localparam logic [3:0]       LAST_BIT8  = 4'h7;
   localparam logic [3:0]       LAST_BIT9  = 4'h8;
   // ****************************************
   // receiver states
   // ****************************************
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_START,
      ST_DATA,
      ST_STOP
   } usrbg_state_e;
endpackage

// file: rtl/usrbg_baud_gen.sv
`timescale 1ns/10ps
module usrbg_baud_gen
   import usrbg_pkg::*;
#(
   parameter int DIV_W = BAUD_W
)(
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   // control
   input  wire logic [DIV_W-1:0] i_divisor,
   input  wire logic             i_reload,
   input  wire logic             i_high,
   input  wire logic             i_sync,
   // ticks
   output logic                  o_os_tick,
   output logic                  o_sync_tick,
   output logic                  o_sync_clk
);
   // ****************************************
   // timer and prescaler
   // ****************************************
   logic [DIV_W-1:0] cnt_reg;
   logic             tick_reg;
   logic [1:0]       pre_reg;
   logic             sclk_reg;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end else if (i_reload) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end else if (cnt_reg == i_divisor) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b1;
      end else begin
         cnt_reg  <= cnt_reg + 1'b1;
         tick_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pre_reg <= 2'h0;
      end else if (i_reload) begin
         pre_reg <= 2'h0;
      end else if (tick_reg) begin
         pre_reg <= pre_reg + 2'h1;
      end
   end

   // master clock toggles every second tick: period of four ticks
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sclk_reg <= 1'b0;
      end else if (tick_reg && i_sync && pre_reg[0]) begin
         sclk_reg <= !sclk_reg;
      end
   end

   assign o_os_tick   = tick_reg && !i_sync && (i_high || pre_reg == PRE_LAST);
   assign o_sync_tick = tick_reg && i_sync && pre_reg == PRE_LAST;
   assign o_sync_clk  = sclk_reg;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_hold_div3;
      (!i_reload && i_divisor == 8'h03) [*4];
   endsequence
   property p_reload_clear;
      i_reload ##1 s_hold_div3 |-> !tick_reg ##1 tick_reg;
   endproperty
   a_reload_clear: assert property (p_reload_clear) else $error("timer not cleared");
   property p_period;
      (tick_reg && !i_reload && i_divisor == 8'h02) ##1
      (!i_reload && i_divisor == 8'h02) [*3] |-> tick_reg && !$past(tick_reg);
   endproperty
   a_period: assert property (p_period) else $error("timer period wrong");
   property p_high;
      (cnt_reg == i_divisor && !i_reload) ##1 (i_high && !i_sync) |-> o_os_tick;
   endproperty
   a_high: assert property (p_high) else $error("high speed tick missing");
   property p_low;
      o_os_tick && !i_high && !i_reload |=> !o_os_tick [*3];
   endproperty
   a_low: assert property (p_low) else $error("low speed tick too fast");
   property p_sync;
      o_sync_tick && !i_reload |=> !o_sync_tick [*3];
   endproperty
   a_sync: assert property (p_sync) else $error("sync tick too fast");
   property p_sync_no_high;
      i_sync |-> !o_os_tick;
   endproperty
   a_sync_no_high: assert property (p_sync_no_high) else $error("high select used in sync");
endmodule // usrbg_baud_gen

// file: rtl/usrbg_majority.sv
`timescale 1ns/10ps
module usrbg_majority
   import usrbg_pkg::*;
(
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // samples
   input  wire logic       i_os_tick,
   input  wire logic [3:0] i_phase,
   input  wire logic       i_rx,
   // decision
   output logic            o_bit,
   output logic            o_valid
);
   // ****************************************
   // three mid-bit samples and vote
   // ****************************************
   logic [1:0] samp_reg;
   logic       bit_reg;
   logic       valid_reg;
   logic       last;

   assign last = i_os_tick && i_phase == SAMP_LAST;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         samp_reg <= 2'h3;
      end else if (i_os_tick && i_phase == SAMP_FIRST) begin
         samp_reg[0] <= i_rx;
      end else if (i_os_tick && i_phase == SAMP_MID) begin
         samp_reg[1] <= i_rx;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bit_reg   <= 1'b1;
         valid_reg <= 1'b0;
      end else begin
         valid_reg <= last;
         if (last) begin
            bit_reg <= (samp_reg[0] & samp_reg[1]) | ((samp_reg[0] | samp_reg[1]) & i_rx);
         end
      end
   end

   assign o_bit   = bit_reg;
   assign o_valid = valid_reg;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_last;
      i_os_tick && i_phase == SAMP_LAST;
   endsequence
   property p_two_low;
      s_last ##0 (!i_rx && !samp_reg[1]) |=> o_valid && !o_bit;
   endproperty
   a_two_low: assert property (p_two_low) else $error("majority low lost");
   property p_two_high;
      s_last ##0 (i_rx && samp_reg[0]) |=> o_valid && o_bit;
   endproperty
   a_two_high: assert property (p_two_high) else $error("majority high lost");
endmodule // usrbg_majority

// file: rtl/usrbg_top.sv
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
// Behaviour
// - baud timer is a free-running 8-bit counter whose period the divisor sets
// - high baud select only matters in asynchronous mode
// - async low speed bit rate is clock over 64 times divisor plus one
// - async high speed bit rate is clock over 16 times divisor plus one
// - synchronous bit rate is clock over 4 times divisor plus one
// - divide formulas drive the clock pin only as master; slave follows pin clock
// - a divisor write clears the baud timer at once
// - each bit is decided by majority of three mid-bit samples
// - async reception runs only while continuous receive enable is set
module usrbg_top
   import usrbg_pkg::*;
(
   // clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_arst_n,
   // register port
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // serial pins
   input  wire logic       i_receive_data_pin,
   input  wire logic       i_transmit_clock_pin,
   output logic            o_transmit_clock_pin,
   output logic            o_transmit_clock_pin_oe_n,
   // status
   output logic            o_sync_bit_tick,
   output logic            o_irq
);
   // ****************************************
   // reset release
   // ****************************************
   logic rst_s1_reg;
   logic rst_s2_reg;
   logic rst_n;

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end

   assign rst_n = rst_s2_reg;

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic rx_s1_reg;
   logic rx_s2_reg;
   logic ck_s1_reg;
   logic ck_s2_reg;
   logic ck_s3_reg;

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
         ck_s1_reg <= 1'b0;
         ck_s2_reg <= 1'b0;
         ck_s3_reg <= 1'b0;
      end else begin
         rx_s1_reg <= i_receive_data_pin;
         rx_s2_reg <= rx_s1_reg;
         ck_s1_reg <= i_transmit_clock_pin;
         ck_s2_reg <= ck_s1_reg;
         ck_s3_reg <= ck_s2_reg;
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   logic             serial_port_enable_reg;
   logic             nine_reg;
   logic             single_receive_enable_reg;
   logic             continuous_receive_enable_reg;
   logic             master_reg;
   logic             sync_reg;
   logic             high_reg;
   logic [7:0]       div_reg;
   logic [IRQ_W-1:0] ien_reg;
   logic             wr_rsc;
   logic             wr_tsc;
   logic             wr_div;
   logic             wr_ien;
   logic             wr_iclr;
   logic             rd_hold;

   assign wr_rsc  = i_wr && (i_addr == RSC_ADDR);
   assign wr_tsc  = i_wr && (i_addr == TSC_ADDR);
   assign wr_div  = i_wr && (i_addr == DIV_ADDR);
   assign wr_ien  = i_wr && (i_addr == IEN_ADDR);
   assign wr_iclr = i_wr && (i_addr == ICLR_ADDR);
   assign rd_hold = i_rd && (i_addr == HOLD_ADDR);

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_port_enable_reg <= 1'b0;
         nine_reg <= 1'b0;
         single_receive_enable_reg <= 1'b0;
         continuous_receive_enable_reg <= 1'b0;
      end else if (wr_rsc) begin
         serial_port_enable_reg <= i_wdata[RSC_SERIAL_PORT_ENABLE];
         nine_reg <= i_wdata[RSC_NINE];
         single_receive_enable_reg <= i_wdata[RSC_SINGLE_RECEIVE_ENABLE];
         continuous_receive_enable_reg <= i_wdata[RSC_CONTINUOUS_RECEIVE_ENABLE];
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         master_reg <= 1'b0;
         sync_reg   <= 1'b0;
         high_reg   <= 1'b0;
      end else if (wr_tsc) begin
         master_reg <= i_wdata[TSC_MASTER];
         sync_reg   <= i_wdata[TSC_SYNC];
         high_reg   <= i_wdata[TSC_HIGH];
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= DIV_RST;
      end else if (wr_div) begin
         div_reg <= i_wdata;
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ien_reg <= IRQ_RST;
      end else if (wr_ien) begin
         ien_reg <= i_wdata[IRQ_W-1:0];
      end
   end

   // ****************************************
   // baud generator and sampler
   // ****************************************
   logic       high_eff;
   logic       rx_en;
   logic       os_tick;
   logic       gen_sync_tick;
   logic       gen_sync_clk;
   logic       maj_bit;
   logic       maj_valid;
   logic [3:0] phase_reg;

   assign high_eff = high_reg && !sync_reg;
   assign rx_en    = serial_port_enable_reg && continuous_receive_enable_reg && !sync_reg;

   usrbg_baud_gen #(
      .DIV_W       (BAUD_W)
   ) u_baud (
      .i_clk       (i_core_clk),
      .i_rst_n     (rst_n),
      .i_divisor   (div_reg),
      .i_reload    (wr_div),
      .i_high      (high_eff),
      .i_sync      (sync_reg),
      .o_os_tick   (os_tick),
      .o_sync_tick (gen_sync_tick),
      .o_sync_clk  (gen_sync_clk)
   );

   usrbg_majority u_major (
      .i_clk       (i_core_clk),
      .i_rst_n     (rst_n),
      .i_os_tick   (os_tick),
      .i_phase     (phase_reg),
      .i_rx        (rx_s2_reg),
      .o_bit       (maj_bit),
      .o_valid     (maj_valid)
   );

   // ****************************************
   // asynchronous receiver
   // ****************************************
   usrbg_state_e state_reg;
   logic [3:0]   bitn_reg;
   logic [8:0]   shift_reg;
   logic [3:0]   last_bit;

   assign last_bit = nine_reg ? LAST_BIT9 : LAST_BIT8;

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         phase_reg <= PHASE_ZERO;
         bitn_reg  <= 4'h0;
         shift_reg <= 9'h000;
      end else if (!rx_en) begin
         state_reg <= ST_IDLE;
         phase_reg <= PHASE_ZERO;
      end else begin
         if (state_reg != ST_IDLE && os_tick) begin
            phase_reg <= phase_reg + 4'h1;
         end
         case (state_reg)
            ST_IDLE: begin
               if (!rx_s2_reg) begin
                  state_reg <= ST_START;
                  phase_reg <= PHASE_ZERO;
               end
            end
            ST_START: begin
               // a high start bit is a glitch: rearm
               if (maj_valid && maj_bit) begin
                  state_reg <= ST_IDLE;
               end else if (maj_valid) begin
                  state_reg <= ST_DATA;
                  bitn_reg  <= 4'h0;
               end
            end
            ST_DATA: begin
               if (maj_valid) begin
                  shift_reg <= {maj_bit, shift_reg[8:1]};
                  bitn_reg  <= bitn_reg + 4'h1;
                  if (bitn_reg == last_bit) begin
                     state_reg <= ST_STOP;
                  end
               end
            end
            ST_STOP: begin
               if (maj_valid) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // holding register and error flags
   // ****************************************
   logic       deliver;
   logic       store;
   logic       lost;
   logic [7:0] rx_byte;
   logic       rx_ninth;
   logic [7:0] hold_reg;
   logic       hold9_reg;
   logic       full_reg;
   logic       framing_error_flag_reg;
   logic       overrun_error_flag_reg;

   assign deliver  = (state_reg == ST_STOP) && maj_valid && rx_en;
   assign store    = deliver && (!full_reg || rd_hold);
   assign lost     = deliver && full_reg && !rd_hold;
   assign rx_byte  = nine_reg ? shift_reg[7:0] : shift_reg[8:1];
   assign rx_ninth = nine_reg && shift_reg[8];

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_reg  <= 8'h00;
         hold9_reg <= 1'b0;
         full_reg  <= 1'b0;
         framing_error_flag_reg  <= 1'b0;
      end else if (store) begin
         hold_reg  <= rx_byte;
         hold9_reg <= rx_ninth;
         full_reg  <= 1'b1;
         framing_error_flag_reg  <= !maj_bit;
      end else if (rd_hold) begin
         full_reg  <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         overrun_error_flag_reg <= 1'b0;
      end else if (!continuous_receive_enable_reg) begin
         overrun_error_flag_reg <= 1'b0;
      end else if (lost) begin
         overrun_error_flag_reg <= 1'b1;
      end
   end

   // ****************************************
   // interrupt status
   // ****************************************
   logic [IRQ_W-1:0] ist_reg;
   logic [IRQ_W-1:0] events;

   assign events[IRQ_RX]   = store;
   assign events[IRQ_FRAMING_ERROR_FLAG] = store && !maj_bit;
   assign events[IRQ_OVERRUN_ERROR_FLAG] = lost;

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ist_reg <= IRQ_RST;
      end else if (wr_iclr) begin
         ist_reg <= (ist_reg & ~i_wdata[IRQ_W-1:0]) | events;
      end else begin
         ist_reg <= ist_reg | events;
      end
   end

   assign o_irq = |(ist_reg & ien_reg);

   // ****************************************
   // read port
   // ****************************************
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   always_comb begin
      rdata_next = 8'h00;
      if (i_rd) begin
         case (i_addr)
            RSC_ADDR:  rdata_next = {serial_port_enable_reg, nine_reg, single_receive_enable_reg, continuous_receive_enable_reg,
                                     1'b0, framing_error_flag_reg, overrun_error_flag_reg, hold9_reg};
            HOLD_ADDR: rdata_next = hold_reg;
            IST_ADDR:  rdata_next = {5'h00, ist_reg};
            IEN_ADDR:  rdata_next = {5'h00, ien_reg};
            TSC_ADDR:  rdata_next = {master_reg, 2'h0, sync_reg, 1'b0, high_reg, 2'h0};
            DIV_ADDR:  rdata_next = div_reg;
            default:   rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign o_rdata = rdata_reg;

   // ****************************************
   // synchronous clock pin
   // ****************************************
   logic drive_clk;
   logic bit_tick_reg;

   assign drive_clk                 = serial_port_enable_reg && sync_reg && master_reg;
   assign o_transmit_clock_pin_oe_n = !drive_clk;
   assign o_transmit_clock_pin      = gen_sync_clk;

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_tick_reg <= 1'b0;
      end else if (master_reg) begin
         bit_tick_reg <= serial_port_enable_reg && sync_reg && gen_sync_tick;
      end else begin
         bit_tick_reg <= serial_port_enable_reg && sync_reg && ck_s2_reg && !ck_s3_reg;
      end
   end

   assign o_sync_bit_tick = bit_tick_reg;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_lost;
      deliver && full_reg && !rd_hold;
   endsequence
   property p_rx_gate;
      !rx_en |=> state_reg == ST_IDLE;
   endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("receiver ran while disabled");
   property p_overrun_error_flag_set;
      s_lost ##0 continuous_receive_enable_reg |=> overrun_error_flag_reg && full_reg;
   endproperty
   a_overrun_error_flag_set: assert property (p_overrun_error_flag_set) else $error("overrun not flagged");
   property p_overrun_error_flag_clr;
      !continuous_receive_enable_reg |=> !overrun_error_flag_reg;
   endproperty
   a_overrun_error_flag_clr: assert property (p_overrun_error_flag_clr) else $error("overrun not cleared");
   property p_framing_error_flag;
      $changed(framing_error_flag_reg) |-> $past(store) && framing_error_flag_reg == !$past(maj_bit);
   endproperty
   a_framing_error_flag: assert property (p_framing_error_flag) else $error("framing flag wrong");
   property p_ninth;
      store && !nine_reg |=> !hold9_reg && full_reg;
   endproperty
   a_ninth: assert property (p_ninth) else $error("ninth bit set in 8-bit mode");
   property p_bit3;
      i_rd && i_addr == RSC_ADDR |=> !o_rdata[3];
   endproperty
   a_bit3: assert property (p_bit3) else $error("unused bit reads one");
   property p_slave_pin;
      !master_reg || !sync_reg || !serial_port_enable_reg |-> o_transmit_clock_pin_oe_n;
   endproperty
   a_slave_pin: assert property (p_slave_pin) else $error("clock pin driven as slave");
endmodule // usrbg_top

// file: dv/usrbg_serial_peer.sv
`timescale 1ns/10ps
// ****************************************
// serial peer: lsb-first frames on the receive line
// ****************************************
module usrbg_serial_peer (
   input  wire logic i_clk,
   output logic      o_line
);
   initial o_line = 1'b1;
   // a bad stop is cut short so the line is high again before a false start is voted
   task automatic send(input logic [8:0] d, input int nb, input int per,
                       input logic stp, input logic glitch);
      logic v;
      for (int b = 0; b < nb + 2; b++) begin
         v = (b == 0) ? 1'b0 : (b > nb) ? stp : d[b-1];
         for (int c = 0; c < ((b > nb && !stp) ? per * 3 / 4 : per); c++) begin
            @(posedge i_clk);
            o_line <= (glitch && c == per / 2) ? ~v : v;
         end
      end
      @(posedge i_clk);
      o_line <= 1'b1;
   endtask
endmodule // usrbg_serial_peer

// file: dv/usrbg_tb_top.sv
`timescale 1ns/10ps
module usrbg_tb_top
   import usrbg_pkg::*;
;
   // ****************************************
   // signals and models
   // ****************************************
   logic       clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, pclk = 0;
   logic [7:0] addr = 0, wdata = 0, rdata, x;
   logic [8:0] d;
   logic       oe_n, tick, irq, h, n, pin, pin_d = 1'b0;
   int         pgap = 0, plast = 0;
   wire        rx;
   int         err_total = 0, samples_checked = 0, seed = 8, cyc = 0, last = 0, gap = 0;
   logic [7:0] q[$];
   logic [7:0] ra[7] = '{RSC_ADDR, HOLD_ADDR, IST_ADDR, IEN_ADDR, TSC_ADDR, DIV_ADDR, 8'h55};

   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (tick === 1'b1) begin
         gap = cyc - last;
         last = cyc;
      end
      if (pin === 1'b1 && pin_d === 1'b0) begin
         pgap = cyc - plast;
         plast = cyc;
      end
      pin_d = pin;
   end

   usrbg_serial_peer peer (.i_clk(clk), .o_line(rx));
   usrbg_top DUT (.i_core_clk(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_receive_data_pin(rx),
      .i_transmit_clock_pin(pclk), .o_transmit_clock_pin(pin), .o_transmit_clock_pin_oe_n(oe_n),
      .o_sync_bit_tick(tick), .o_irq(irq));

   // ****************************************
   // tasks
   // ****************************************
   task chk(input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, s, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      wr_s <= 1'b1; addr <= a; wdata <= v;
      @(posedge clk);
      wr_s <= 1'b0;
      #1;
   endtask
   task rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      rd_s <= 1'b1; addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task frame(input logic [8:0] v, input int nb, input int per, input logic stp);
      q.push_back(v[7:0]);
      peer.send(v, nb, per, stp, 1'b1);
   endtask
   task final_report;
      $display("err_total %0d samples_checked %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      final_report;
   end

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (ra[i]) rchk(ra[i], 8'h00);
      x = 8'($random(seed));
      wr(DIV_ADDR, x);
      rchk(DIV_ADDR, x);
      rchk(ICLR_ADDR, 8'h00);
      wr(DIV_ADDR, 8'h03);
      repeat (6) @(posedge clk);
      // sync master, high select both ways, then divisor rewrite
      for (int i = 0; i < 2; i++) begin
         h = i[0];
         wr(DIV_ADDR, 8'h02);
         wr(TSC_ADDR, {5'h12, h, 2'h0});
         wr(RSC_ADDR, 8'h80);
         repeat (40) @(posedge clk);
         chk(8'(gap), 8'h0c);
         chk(8'(pgap), 8'h0c);
         chk(8'(oe_n), 8'h00);
      end
      wr(DIV_ADDR, 8'h00);
      repeat (20) @(posedge clk);
      chk(8'(gap), 8'h04);
      // sync slave follows the pin clock
      wr(TSC_ADDR, 8'h10);
      chk(8'(oe_n), 8'h01);
      repeat (6) begin
         repeat (10) @(posedge clk);
         pclk <= ~pclk;
      end
      chk(8'(gap), 8'h14);
      // async frames: low speed, high speed, nine bits
      wr(IEN_ADDR, 8'h07);
      for (int i = 0; i < 3; i++) begin
         h = (i > 0);
         n = (i == 2);
         x = 8'(h);
         wr(DIV_ADDR, x);
         wr(TSC_ADDR, {5'h0, h, 2'h0});
         wr(RSC_ADDR, {1'b1, n, 6'h10});
         d = 9'($random(seed));
         frame(d, n ? 9 : 8, (h ? 16 : 64) * (int'(x) + 1), 1'b1);
         rchk(RSC_ADDR, {1'b1, n, 5'h08, n & d[8]});
         chk(8'(irq), 8'h01);
         rchk(HOLD_ADDR, q.pop_front());
         wr(ICLR_ADDR, 8'h07);
         rchk(IST_ADDR, 8'h00);
         chk(8'(irq), 8'h00);
      end
      // framing error, then cleared by read and a clean byte
      wr(RSC_ADDR, 8'h90);
      frame(9'($random(seed)), 8, 32, 1'b0);
      // the receiver rearms after the false start behind the cut stop bit
      repeat (32) @(posedge clk);
      rchk(RSC_ADDR, 8'h94);
      rchk(HOLD_ADDR, q.pop_front());
      frame(9'($random(seed)), 8, 32, 1'b1);
      rchk(RSC_ADDR, 8'h90);
      rchk(HOLD_ADDR, q.pop_front());
      wr(ICLR_ADDR, 8'h07);
      // overrun: second byte lost, flag drops with continuous enable
      frame(9'($random(seed)), 8, 32, 1'b1);
      frame(9'($random(seed)), 8, 32, 1'b1);
      rchk(RSC_ADDR, 8'h92);
      rchk(HOLD_ADDR, q.pop_front());
      void'(q.pop_front());
      rchk(IST_ADDR, 8'h05);
      wr(IEN_ADDR, 8'h00);
      chk(8'(irq), 8'h00);
      wr(IEN_ADDR, 8'h04);
      chk(8'(irq), 8'h01);
      wr(ICLR_ADDR, 8'h07);
      wr(RSC_ADDR, 8'h80);
      rchk(RSC_ADDR, 8'h80);
      peer.send(9'h0a5, 8, 32, 1'b1, 1'b0);
      rchk(IST_ADDR, 8'h00);
      final_report;
   end
endmodule // usrbg_tb_top
